// ---- include/topc_pkg.sv ----
// Purpose: Shared constants and types of the target output and position compare block
// Assumes: AHB-Lite word registers, byte address is four times the register index
// Notes:   Register index values are kept as printed; see the core for decoding

package topc_pkg;

    // ------------------------------------------------------------
    // Widths and register indices
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned IDX_LSB = 2;
    localparam logic [IDX_W-1:0] IDX_GENERAL = 8'h00;
    localparam logic [IDX_W-1:0] IDX_REFERENCE = 8'h01;
    localparam logic [IDX_W-1:0] IDX_COMPARE = 8'h32;
    localparam logic [IDX_W-1:0] IDX_HALF_SPAN = 8'h36;
    localparam logic [IDX_W-1:0] IDX_TARGET = 8'h37;
    localparam logic [IDX_W-1:0] IDX_ACTUAL = 8'h38;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h39;
    localparam logic [IDX_W-1:0] IDX_EVENTS = 8'h3A;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned GC_INVERT_BIT = 16;
    localparam int unsigned GC_PULL_EN_BIT = 15;
    localparam int unsigned GC_WIRED_AND_BIT = 14;
    localparam int unsigned GC_REV_AS_LATCH_BIT = 13;
    localparam int unsigned RC_OUT_SEL_LSB = 24;
    localparam int unsigned RC_SOURCE_BIT = 26;
    localparam int unsigned RC_MODE_LSB = 27;
    localparam int unsigned RC_ZERO_ARRIVE_BIT = 29;
    localparam int unsigned RC_CIRCULAR_BIT = 30;
    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
    localparam logic signed [DATA_W-1:0] POS_ZERO = 32'sh0000_0000;
    localparam logic signed [DATA_W-1:0] POS_ONE = 32'sh0000_0001;

    // Status and event bit positions
    localparam int unsigned ST_TARGET = 0;
    localparam int unsigned ST_VELOCITY = 1;
    localparam int unsigned ST_ENC_FAIL = 2;
    localparam int unsigned ST_COMPARE = 3;
    localparam int unsigned ST_LINE = 4;
    localparam int unsigned EV_TARGET = 0;
    localparam int unsigned EV_COMPARE = 1;
    localparam int unsigned EV_W = 2;

    // ------------------------------------------------------------
    // Encodings and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_TARGET = 2'b00,
        SEL_VELOCITY = 2'b01,
        SEL_ENC_FAIL = 2'b10,
        SEL_COMPARE = 2'b11
    } topc_out_sel_type;

    typedef enum logic [1:0] {
        CMP_VALUE = 2'b00,
        CMP_HOME = 2'b01,
        CMP_LATCH = 2'b10,
        CMP_REV = 2'b11
    } topc_cmp_mode_type;

    typedef struct packed {
        logic signed [DATA_W-1:0] enc_pos;
        logic signed [DATA_W-1:0] home_pos;
        logic signed [DATA_W-1:0] int_latch;
        logic signed [DATA_W-1:0] enc_latch;
    } topc_pos_type;

endpackage

// ---- design/topc_core.sv ----
// Purpose: Target output pin, position comparator, repetitive and circular motion
// Assumes: Step pulses, encoder position and latches arrive from logic on clk_i
// Notes:   Zero-wait AHB-Lite slave; read of the event register clears it

`timescale 1ns/1ps

// Function
// - Pin follows target hit flag by default
// - Pin high active, bit 16 inverts it
// - Wired-or: inactive weak, active strong
// - Wired-and: inactive strong, active weak
// - Wired-and select zero means wired-or once pull enable bit 15 is set
// - Two-bit field selects one of four flags
// - Comparator always runs, flag plus event
// - Source 0 compares actual position
// - Source 1 compares encoder position
// - Encoder compare value in microsteps
// - Encoder crossing sets event, not flag
// - Mode field picks compare operands
// - Compare event offered as interrupt source
// - Without repeat, arrival ends positioning ramp
// - Repeat: zero position, restart if target nonzero
// - Target changes allowed, zero on equality
// - Circular: limit loads opposite limit
// - Several hit pins may share a line
// - Range is minus span to span minus one
// - Revolution counter follows wraps
module topc_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Motion inputs
    input wire logic step_i,
    input wire logic step_dir_i,
    input wire logic vel_reached_i,
    input wire logic enc_fail_i,
    input wire topc_pkg::topc_pos_type pos_i,
    // Shared hit line, open-drain style
    input wire logic hit_pin_i,
    output logic hit_pin_o,
    output logic hit_pin_oe_o,
    output logic hit_pin_weak_o,
    // Motion outputs
    output logic ramp_done_o,
    output logic ramp_restart_o,
    output logic compare_event_o,
    output logic signed [31:0] actual_position_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] general_r, general_nxt;
    logic [31:0] reference_r, reference_nxt;
    logic signed [31:0] compare_r, compare_nxt;
    logic signed [31:0] half_span_r, half_span_nxt;
    logic signed [31:0] target_r, target_nxt;
    logic signed [31:0] actual_r, actual_nxt;
    logic signed [31:0] rev_r, rev_nxt;
    logic signed [31:0] enc_prev_r, enc_prev_nxt;
    logic [topc_pkg::EV_W-1:0] events_r, events_nxt;
    logic hit_prev_r, hit_prev_nxt;
    logic match_prev_r, match_prev_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [topc_pkg::IDX_W-1:0] wr_idx_r, wr_idx_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic done_r, done_nxt;
    logic restart_r, restart_nxt;
    logic cmp_ev_r, cmp_ev_nxt;
    logic line_meta_r, line_sync_r;

    // Configuration decode
    logic invert, pull_en, wired_and, rev_as_latch, source, zero_arrive, circular;
    logic [1:0] out_sel, cmp_mode;
    assign invert = general_r[topc_pkg::GC_INVERT_BIT];
    assign pull_en = general_r[topc_pkg::GC_PULL_EN_BIT];
    assign wired_and = general_r[topc_pkg::GC_WIRED_AND_BIT];
    assign rev_as_latch = general_r[topc_pkg::GC_REV_AS_LATCH_BIT];
    assign out_sel = reference_r[topc_pkg::RC_OUT_SEL_LSB +: 2];
    assign source = reference_r[topc_pkg::RC_SOURCE_BIT];
    assign cmp_mode = reference_r[topc_pkg::RC_MODE_LSB +: 2];
    assign zero_arrive = reference_r[topc_pkg::RC_ZERO_ARRIVE_BIT];
    // A zero span would collapse the range, so circular stays off
    assign circular = reference_r[topc_pkg::RC_CIRCULAR_BIT] && (half_span_r != topc_pkg::POS_ZERO);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic accept, rd_accept, sw_actual;
    logic [topc_pkg::IDX_W-1:0] a_idx;
    assign accept = hsel_i && htrans_i[1] && hready_i;
    assign rd_accept = accept && !hwrite_i;
    assign a_idx = haddr_i[topc_pkg::IDX_LSB +: topc_pkg::IDX_W];
    assign sw_actual = wr_pend_r && (wr_idx_r == topc_pkg::IDX_ACTUAL);

    // ------------------------------------------------------------
    // Flags and comparator
    // ------------------------------------------------------------
    logic hit, match, crossed, sel_flag, active;
    logic signed [31:0] operand, ref_val;
    logic [31:0] status;

    // Operand selection and equality test, every cycle
    always_comb begin
        operand = source ? pos_i.enc_pos : actual_r;
        ref_val = compare_r;
        unique case (topc_pkg::topc_cmp_mode_type'(cmp_mode))
            topc_pkg::CMP_VALUE: ref_val = compare_r;
            topc_pkg::CMP_HOME: ref_val = pos_i.home_pos;
            topc_pkg::CMP_LATCH: ref_val = source ? pos_i.enc_latch : pos_i.int_latch;
            topc_pkg::CMP_REV: begin
                operand = rev_r;
                ref_val = compare_r;
            end
        endcase
        hit = (actual_r == target_r);
        match = (operand == ref_val);
        // Encoder may jump over the value; the event still records it
        crossed = source && (cmp_mode != topc_pkg::CMP_REV)
            && (((enc_prev_r < ref_val) && (pos_i.enc_pos > ref_val))
            || ((enc_prev_r > ref_val) && (pos_i.enc_pos < ref_val)));
    end

    // Output source mux and pin drive
    always_comb begin
        unique case (topc_pkg::topc_out_sel_type'(out_sel))
            topc_pkg::SEL_TARGET: sel_flag = hit;
            topc_pkg::SEL_VELOCITY: sel_flag = vel_reached_i;
            topc_pkg::SEL_ENC_FAIL: sel_flag = enc_fail_i;
            topc_pkg::SEL_COMPARE: sel_flag = match;
        endcase
        active = sel_flag;
        hit_pin_o = active ^ invert;
        hit_pin_oe_o = 1'b1;
        // Weak drive lets other pins on the line win
        if (!pull_en) begin
            hit_pin_weak_o = 1'b0;
        end else if (wired_and) begin
            hit_pin_weak_o = active;
        end else begin
            hit_pin_weak_o = !active;
        end
    end

    // Status word
    always_comb begin
        status = topc_pkg::REG_RESET;
        status[topc_pkg::ST_TARGET] = hit;
        status[topc_pkg::ST_VELOCITY] = vel_reached_i;
        status[topc_pkg::ST_ENC_FAIL] = enc_fail_i;
        status[topc_pkg::ST_COMPARE] = match;
        status[topc_pkg::ST_LINE] = line_sync_r;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        general_nxt = general_r;
        reference_nxt = reference_r;
        compare_nxt = compare_r;
        half_span_nxt = half_span_r;
        target_nxt = target_r;
        actual_nxt = actual_r;
        rev_nxt = rev_r;
        wr_pend_nxt = accept && hwrite_i;
        wr_idx_nxt = accept ? a_idx : wr_idx_r;
        rdata_nxt = rdata_r;
        hit_prev_nxt = hit;
        match_prev_nxt = match;
        enc_prev_nxt = pos_i.enc_pos;
        done_nxt = hit && !zero_arrive;
        restart_nxt = 1'b0;
        cmp_ev_nxt = (match && !match_prev_r) || crossed;
        events_nxt = events_r;
        // Position: step with optional circular wrap
        if (step_i) begin
            if (circular && step_dir_i && (actual_r == half_span_r - topc_pkg::POS_ONE)) begin
                actual_nxt = -half_span_r;
                rev_nxt = rev_r + topc_pkg::POS_ONE;
            end else if (circular && !step_dir_i && (actual_r == -half_span_r)) begin
                actual_nxt = half_span_r - topc_pkg::POS_ONE;
                rev_nxt = rev_r - topc_pkg::POS_ONE;
            end else if (step_dir_i) begin
                actual_nxt = actual_r + topc_pkg::POS_ONE;
            end else begin
                actual_nxt = actual_r - topc_pkg::POS_ONE;
            end
        end
        // Arrival in repeat mode wins over a step in the same cycle
        if (hit && zero_arrive) begin
            actual_nxt = topc_pkg::POS_ZERO;
            restart_nxt = (target_r != topc_pkg::POS_ZERO);
        end
        if (!circular) begin
            rev_nxt = topc_pkg::POS_ZERO;
        end
        // Read in address phase; event read clears
        if (rd_accept) begin
            unique case (a_idx)
                topc_pkg::IDX_GENERAL: rdata_nxt = general_r;
                topc_pkg::IDX_REFERENCE: rdata_nxt = reference_r;
                topc_pkg::IDX_COMPARE: rdata_nxt = compare_r;
                topc_pkg::IDX_HALF_SPAN: rdata_nxt = rev_as_latch ? rev_r : pos_i.int_latch;
                topc_pkg::IDX_TARGET: rdata_nxt = target_r;
                topc_pkg::IDX_ACTUAL: rdata_nxt = actual_r;
                topc_pkg::IDX_STATUS: rdata_nxt = status;
                topc_pkg::IDX_EVENTS: rdata_nxt = {{(32-topc_pkg::EV_W){1'b0}}, events_r};
                default: rdata_nxt = topc_pkg::REG_RESET;
            endcase
            if (a_idx == topc_pkg::IDX_EVENTS) begin
                events_nxt = '0;
            end
        end
        // Hardware set wins over read clear
        if (hit && !hit_prev_r) begin
            events_nxt[topc_pkg::EV_TARGET] = 1'b1;
        end
        if (cmp_ev_nxt) begin
            events_nxt[topc_pkg::EV_COMPARE] = 1'b1;
        end
        // Data phase write; software owns the position that cycle
        if (wr_pend_r) begin
            unique case (wr_idx_r)
                topc_pkg::IDX_GENERAL: general_nxt = hwdata_i;
                topc_pkg::IDX_REFERENCE: reference_nxt = hwdata_i;
                topc_pkg::IDX_COMPARE: compare_nxt = hwdata_i;
                topc_pkg::IDX_HALF_SPAN: half_span_nxt = hwdata_i;
                topc_pkg::IDX_TARGET: target_nxt = hwdata_i;
                topc_pkg::IDX_ACTUAL: actual_nxt = hwdata_i;
                default: general_nxt = general_r;
            endcase
        end
    end

    // Register update
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            general_r <= topc_pkg::REG_RESET;
            reference_r <= topc_pkg::REG_RESET;
            compare_r <= topc_pkg::POS_ZERO;
            half_span_r <= topc_pkg::POS_ZERO;
            target_r <= topc_pkg::POS_ZERO;
            actual_r <= topc_pkg::POS_ZERO;
            rev_r <= topc_pkg::POS_ZERO;
            enc_prev_r <= topc_pkg::POS_ZERO;
            events_r <= '0;
            hit_prev_r <= 1'b0;
            match_prev_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_idx_r <= topc_pkg::IDX_GENERAL;
            rdata_r <= topc_pkg::REG_RESET;
            done_r <= 1'b0;
            restart_r <= 1'b0;
            cmp_ev_r <= 1'b0;
            line_meta_r <= 1'b0;
            line_sync_r <= 1'b0;
        end else begin
            general_r <= general_nxt;
            reference_r <= reference_nxt;
            compare_r <= compare_nxt;
            half_span_r <= half_span_nxt;
            target_r <= target_nxt;
            actual_r <= actual_nxt;
            rev_r <= rev_nxt;
            enc_prev_r <= enc_prev_nxt;
            events_r <= events_nxt;
            hit_prev_r <= hit_prev_nxt;
            match_prev_r <= match_prev_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_idx_r <= wr_idx_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
            restart_r <= restart_nxt;
            cmp_ev_r <= cmp_ev_nxt;
            line_meta_r <= hit_pin_i;
            line_sync_r <= line_meta_r;
        end
    end

    // Output drive
    assign hrdata_o = rdata_r;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign ramp_done_o = done_r;
    assign ramp_restart_o = restart_r;
    assign compare_event_o = cmp_ev_r;
    assign actual_position_o = actual_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_default_pin_source: assert property (
        (out_sel == topc_pkg::SEL_TARGET) && !invert |-> hit_pin_o == (actual_r == target_r))
        else $error("hit pin does not follow target hit");
    a_pin_inverted: assert property (
        invert && (out_sel == topc_pkg::SEL_COMPARE) |-> hit_pin_o == !match)
        else $error("inverted pin polarity wrong");
    a_wired_or_drive: assert property (
        pull_en && !wired_and |-> hit_pin_weak_o == (hit_pin_o == invert))
        else $error("wired-or drive strength wrong");
    a_wired_and_drive: assert property (
        pull_en && wired_and |-> hit_pin_weak_o == (hit_pin_o != invert))
        else $error("wired-and drive strength wrong");
    a_compare_event: assert property (
        match && !match_prev_r |=> events_r[topc_pkg::EV_COMPARE] && compare_event_o)
        else $error("compare match lost its event");
    a_zero_arrival: assert property (
        hit && zero_arrive && !sw_actual |=> actual_r == topc_pkg::POS_ZERO
            && ramp_restart_o == ($past(target_r) != topc_pkg::POS_ZERO))
        else $error("repeat mode did not clear position");
    a_positive_wrap: assert property (
        circular && step_i && step_dir_i && (actual_r == half_span_r - topc_pkg::POS_ONE)
            && !hit && !sw_actual
        |=> actual_r == -$past(half_span_r) && rev_r == $past(rev_r) + topc_pkg::POS_ONE)
        else $error("positive wrap wrong");
    a_rev_cleared: assert property (
        !circular |=> rev_r == topc_pkg::POS_ZERO)
        else $error("revolution counter not cleared");
    a_ramp_end: assert property (
        hit && !zero_arrive |=> ramp_done_o ##1 (ramp_done_o == ($past(hit) && !$past(zero_arrive))))
        else $error("arrival did not end the ramp");

endmodule // topc_core

// ---- tb/topc_line_model.sv ----
// Purpose: Shared hit line with one peer device hanging on it
// Assumes: A strong drive beats a weak drive on the line
// Notes:   Peer wins any tie, so a wrong strength shows up at once

`timescale 1ns/1ps

module topc_line_model (
    // Our device
    input wire logic dut_lvl_i,
    input wire logic dut_oe_i,
    input wire logic dut_weak_i,
    // Peer device, driven by the bench
    input wire logic peer_lvl_i,
    input wire logic peer_weak_i,
    // Resolved line
    output logic line_o
);
    // ------------------------------------------------------------
    // Line resolution
    // ------------------------------------------------------------
    // Strong beats weak; ties go to the peer
    always_comb begin
        if (dut_oe_i && !dut_weak_i && peer_weak_i) begin
            line_o = dut_lvl_i;
        end else begin
            line_o = peer_lvl_i;
        end
    end
endmodule // topc_line_model

// ---- tb/test_topc_core.sv ----
// Purpose: Self-checking bench of the target output and position compare block
// Assumes: Zero-wait AHB-Lite slave, byte address is four times the index
// Notes:   Flags are checked two edges after a write to let registers land

`timescale 1ns/1ps

module test_topc_core;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [1:0] htrans_i = 2'b00;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'b010;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic step_i = 1'b0;
    logic step_dir_i = 1'b0;
    logic vel_i = 1'b0;
    logic encf_i = 1'b0;
    topc_pkg::topc_pos_type pos_i = '0;
    logic line, hit_o, hit_oe, hit_weak, done_o, rst_o, cev_o;
    logic signed [31:0] act_o;
    logic peer_lvl = 1'b0;
    logic peer_weak = 1'b1;
    logic [31:0] rd;
    int num_errors = 0;
    int total_checks = 0;
    int n_cev = 0;
    int n_rst = 0;

    // Clock of 100 ns
    always #50 clk_i = ~clk_i;

    // Pulse counters, sampled mid-cycle so they never race the scenario tasks
    always @(negedge clk_i) begin
        if (cev_o === 1'b1) n_cev++;
        if (rst_o === 1'b1) n_rst++;
    end

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    topc_core u_topc_core (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .step_i(step_i), .step_dir_i(step_dir_i), .vel_reached_i(vel_i), .enc_fail_i(encf_i),
        .pos_i(pos_i), .hit_pin_i(line), .hit_pin_o(hit_o), .hit_pin_oe_o(hit_oe),
        .hit_pin_weak_o(hit_weak), .ramp_done_o(done_o), .ramp_restart_o(rst_o),
        .compare_event_o(cev_o), .actual_position_o(act_o));

    topc_line_model u_topc_line_model (.dut_lvl_i(hit_o), .dut_oe_i(hit_oe), .dut_weak_i(hit_weak),
        .peer_lvl_i(peer_lvl), .peer_weak_i(peer_weak), .line_o(line));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Bounded wait for hready; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 20) begin
            num_errors++;
            $display("MISMATCH hready expected 1 seen timeout");
            test_done();
        end
    endtask

    // One single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        hsel_i <= 1'b1;
        haddr_i <= {22'h00_0000, idx, 2'b00};
        hwrite_i <= w;
        htrans_i <= 2'b10;
        wait_ready();
        htrans_i <= 2'b00;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        wait_ready();
        rd = hrdata_o;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
        repeat (2) @(posedge clk_i);
    endtask

    task automatic rr(input logic [7:0] idx);
        bus(1'b0, idx, 32'h0000_0000);
    endtask

    task automatic step(input logic dir);
        step_i <= 1'b1;
        step_dir_i <= dir;
        @(posedge clk_i);
        step_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    function automatic logic [31:0] bv(input int b);
        return 32'h0000_0001 << b;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("pin", hit_o, 1'b1);
        chk("weak", hit_weak, 1'b0);
        chk("oe", hit_oe, 1'b1);
        rr(topc_pkg::IDX_GENERAL);
        chk("general", rd, topc_pkg::REG_RESET);
        rr(topc_pkg::IDX_REFERENCE);
        chk("reference", rd, topc_pkg::REG_RESET);
        rr(8'h20);
        chk("unmapped", rd, 32'h0000_0000);
        chk("resp", hresp_o, 1'b0);
    endtask

    // Every pin source, then inverted polarity
    task automatic t_select();
        vel_i <= 1'b1;
        wr(topc_pkg::IDX_TARGET, 32'h0000_0005);
        for (int s = 0; s < 4; s++) begin
            wr(topc_pkg::IDX_REFERENCE, 32'(s) << topc_pkg::RC_OUT_SEL_LSB);
            chk("pin_src", hit_o, {31'h0, s[0]});
        end
        wr(topc_pkg::IDX_GENERAL, bv(topc_pkg::GC_INVERT_BIT));
        chk("pin_inv", hit_o, 1'b0);
        wr(topc_pkg::IDX_REFERENCE, 32'h0000_0000);
        chk("pin_inv_tgt", hit_o, 1'b1);
        wr(topc_pkg::IDX_GENERAL, 32'h0000_0000);
        chk("pin_tgt", hit_o, 1'b0);
    endtask

    // Drive strength and the shared line, pull enable written first
    task automatic t_drive();
        peer_lvl <= 1'b1;
        peer_weak <= 1'b0;
        wr(topc_pkg::IDX_GENERAL, bv(topc_pkg::GC_PULL_EN_BIT));
        chk("or_idle_weak", hit_weak, 1'b1);
        rr(topc_pkg::IDX_STATUS);
        chk("or_line_peer", rd[topc_pkg::ST_LINE], 1'b1);
        peer_lvl <= 1'b0;
        peer_weak <= 1'b1;
        wr(topc_pkg::IDX_TARGET, 32'h0000_0000);
        chk("or_act_weak", hit_weak, 1'b0);
        rr(topc_pkg::IDX_STATUS);
        chk("or_line_dut", rd[topc_pkg::ST_LINE], 1'b1);
        wr(topc_pkg::IDX_GENERAL, bv(topc_pkg::GC_PULL_EN_BIT) | bv(topc_pkg::GC_WIRED_AND_BIT));
        chk("and_act_weak", hit_weak, 1'b1);
        peer_lvl <= 1'b1;
        wr(topc_pkg::IDX_TARGET, 32'h0000_0005);
        chk("and_idle_weak", hit_weak, 1'b0);
        rr(topc_pkg::IDX_STATUS);
        chk("and_line", rd[topc_pkg::ST_LINE], 1'b0);
        wr(topc_pkg::IDX_GENERAL, 32'h0000_0000);
    endtask

    // Internal source through all four compare modes
    task automatic t_compare();
        int n0;
        pos_i.home_pos <= 32'sh0000_0003;
        pos_i.int_latch <= 32'sh0000_0007;
        wr(topc_pkg::IDX_ACTUAL, 32'h0000_0003);
        rr(topc_pkg::IDX_EVENTS);
        n0 = n_cev;
        wr(topc_pkg::IDX_COMPARE, 32'h0000_0003);
        chk("cev_pulse", n_cev - n0, 32'h0000_0001);
        rr(topc_pkg::IDX_EVENTS);
        chk("ev_cmp", rd[topc_pkg::EV_COMPARE], 1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(topc_pkg::IDX_REFERENCE, 32'(m) << topc_pkg::RC_MODE_LSB);
            rr(topc_pkg::IDX_STATUS);
            chk("mode_match", rd[topc_pkg::ST_COMPARE], {31'h0, m < 2});
        end
    endtask

    // Encoder source: jump over the value, then land on it
    task automatic t_encoder();
        wr(topc_pkg::IDX_REFERENCE, bv(topc_pkg::RC_SOURCE_BIT));
        wr(topc_pkg::IDX_COMPARE, 32'h0000_0064);
        pos_i.enc_pos <= 32'sh0000_005A;
        repeat (2) @(posedge clk_i);
        rr(topc_pkg::IDX_EVENTS);
        pos_i.enc_pos <= 32'sh0000_006E;
        repeat (2) @(posedge clk_i);
        rr(topc_pkg::IDX_STATUS);
        chk("jump_flag", rd[topc_pkg::ST_COMPARE], 1'b0);
        rr(topc_pkg::IDX_EVENTS);
        chk("jump_event", rd[topc_pkg::EV_COMPARE], 1'b1);
        pos_i.enc_pos <= 32'sh0000_0064;
        repeat (2) @(posedge clk_i);
        rr(topc_pkg::IDX_STATUS);
        chk("enc_flag", rd[topc_pkg::ST_COMPARE], 1'b1);
    endtask

    // Plain arrival, then repetitive motion with a target change
    task automatic t_repeat();
        int n0;
        // Steps stand in for a positioning ramp already chosen by the host
        wr(topc_pkg::IDX_REFERENCE, 32'h0000_0000);
        wr(topc_pkg::IDX_ACTUAL, 32'h0000_0000);
        wr(topc_pkg::IDX_TARGET, 32'h0000_0002);
        step(1'b1);
        step(1'b1);
        chk("done", done_o, 1'b1);
        chk("held", act_o, 32'h0000_0002);
        wr(topc_pkg::IDX_ACTUAL, 32'h0000_0000);
        n0 = n_rst;
        wr(topc_pkg::IDX_REFERENCE, bv(topc_pkg::RC_ZERO_ARRIVE_BIT));
        step(1'b1);
        step(1'b1);
        chk("zeroed", act_o, 32'h0000_0000);
        chk("restart", n_rst - n0, 32'h0000_0001);
        wr(topc_pkg::IDX_TARGET, 32'h0000_0001);
        step(1'b1);
        chk("zeroed2", act_o, 32'h0000_0000);
        wr(topc_pkg::IDX_TARGET, 32'h0000_0000);
        chk("no_restart", n_rst - n0, 32'h0000_0002);
    endtask

    // Circular wrap both ways with the revolution count
    task automatic t_circular();
        wr(topc_pkg::IDX_REFERENCE, 32'h0000_0000);
        wr(topc_pkg::IDX_HALF_SPAN, 32'h0000_0004);
        wr(topc_pkg::IDX_ACTUAL, 32'h0000_0003);
        wr(topc_pkg::IDX_REFERENCE, bv(topc_pkg::RC_CIRCULAR_BIT));
        wr(topc_pkg::IDX_GENERAL, bv(topc_pkg::GC_REV_AS_LATCH_BIT));
        step(1'b1);
        chk("wrap_pos", act_o, 32'hFFFF_FFFC);
        rr(topc_pkg::IDX_HALF_SPAN);
        chk("rev_up", rd, 32'h0000_0001);
        step(1'b0);
        chk("wrap_neg", act_o, 32'h0000_0003);
        rr(topc_pkg::IDX_HALF_SPAN);
        chk("rev_down", rd, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_select();
        t_drive();
        t_compare();
        t_encoder();
        t_repeat();
        t_circular();
        test_done();
    end
endmodule // test_topc_core
